// ---- verilog/usb_cmd_pool_pkg.sv ----
// Constants and carrier types for the command, pool and transmit ring register set
package usb_cmd_pool_pkg;
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_CMD_ADDR = 8'h04;
	localparam logic [7:0] OFS_TX_QUEUE = 8'h08;
	localparam logic [7:0] OFS_POOL_BASE = 8'h0c;
	localparam logic [7:0] OFS_POOL_STRIDE = 8'h08;
	localparam logic [7:0] OFS_POOL_ADDR_SUB = 8'h04;
	localparam logic [7:0] OFS_RING_START = 8'h24;
	localparam logic [7:0] OFS_RING_BOTTOM = 8'h28;
	localparam logic [7:0] OFS_RING_READ = 8'h2c;
	localparam logic [7:0] OFS_RING_WRITE = 8'h30;
	localparam int CMD_BUSY_BIT = 31;
	localparam int CMD_CODE_LSB = 24;
	localparam int ALERT_LSB = 28;
	localparam int QUEUE_FIELD_STRIDE = 8;
	localparam logic [1:0] QUEUE_MAX = 2'h2;
	localparam logic [2:0] CODE_RESERVED = 3'h7;
	localparam logic [31:0] REG_RESET = 32'h0;
	localparam logic [31:0] RING_STEP = 32'h4;

	typedef struct packed {
		logic busy;
		logic [2:0] code;
		logic [15:0] lengthOrEntryCount;
	} cmd_t;

	typedef struct packed {
		logic [2:0] poolAlertThreshold;
		logic [15:0] poolRemainingEntries;
		logic [31:0] dirAddr;
	} pool_t;

	typedef struct packed {
		logic valid;
		logic [1:0] slot;
		logic [15:0] length;
		logic [31:0] addr;
	} tx_req_t;

	typedef struct packed {
		logic [31:0] start;
		logic [31:0] bottom;
		logic [31:0] readPtr;
		logic [31:0] writePtr;
		logic full;
	} ring_t;
endpackage

// ---- verilog/usb_command_pool_mailbox_regs.sv ----
// Command register, receive pool bookkeeping and transmit ring pointers on AHB-Lite
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module usb_command_pool_mailbox_regs
	import usb_cmd_pool_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Transmit engine
	output tx_req_t txReq,
	input wire logic [3:0] txDone,
	// Receive pool consumption
	input wire logic [2:0] poolTake,
	input wire logic [2:0][31:0] poolNextAddr,
	output logic [2:0] poolLowFlag,
	// Transmit ring indications
	input wire logic txIndReq,
	output logic txIndAck,
	output logic txRingFullFlag
);
	cmd_t cmd_q, cmd_d;
	logic [31:0] cmdAddr_q, cmdAddr_d;
	logic [3:0][1:0] depth_q, depth_d;
	pool_t [2:0] pool_q, pool_d;
	logic [2:0] low_q, low_d;
	ring_t ring_q, ring_d;
	tx_req_t txReq_q, txReq_d;
	logic ack_q, ack_d;
	logic wrPend_q, wrPend_d;
	logic [7:0] wrAddr_q, wrAddr_d;
	logic [31:0] rdData_q, rdData_d;
	logic addrPhase;
	logic [31:0] ringNext;
	logic [1:0] slot;
	logic [1:0] pidx;

	assign addrPhase = hsel && htrans[1] && hready;
	assign slot = cmd_q.code[1:0];
	assign pidx = cmd_q.code[1:0];
	// Wrap when the slot just used was the bottom one
	assign ringNext = (ring_q.writePtr >= ring_q.bottom) ? ring_q.start
		: ring_q.writePtr + RING_STEP;

	// Zero wait states: every answer is ready in its first data-phase cycle
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdData_q;
	assign txReq = txReq_q;
	assign poolLowFlag = low_q;
	assign txIndAck = ack_q;
	assign txRingFullFlag = ring_q.full;

	always_comb begin
		cmd_d = cmd_q;
		cmdAddr_d = cmdAddr_q;
		depth_d = depth_q;
		pool_d = pool_q;
		ring_d = ring_q;
		txReq_d = txReq_q;
		txReq_d.valid = 1'b0;
		ack_d = 1'b0;
		wrPend_d = addrPhase && hwrite;
		wrAddr_d = addrPhase ? haddr[7:0] : wrAddr_q;
		rdData_d = rdData_q;

		// Drain first so a completion frees a slot for this cycle's enqueue
		for (int e = 0; e < 4; e++) begin
			if (txDone[e] && depth_q[e] != 2'h0) begin
				depth_d[e] = depth_q[e] - 2'h1;
			end
		end
		for (int p = 0; p < 3; p++) begin
			if (poolTake[p] && pool_q[p].poolRemainingEntries != 16'h0) begin
				pool_d[p].poolRemainingEntries = pool_q[p].poolRemainingEntries - 16'h1;
				pool_d[p].dirAddr = poolNextAddr[p];
			end
		end

		// Command engine: a full endpoint queue keeps the command pending
		if (cmd_q.busy) begin
			if (!cmd_q.code[2]) begin
				if (depth_d[slot] < QUEUE_MAX) begin
					depth_d[slot] = depth_d[slot] + 2'h1;
					txReq_d.valid = 1'b1;
					txReq_d.slot = slot;
					txReq_d.length = cmd_q.lengthOrEntryCount;
					txReq_d.addr = cmdAddr_q;
					cmd_d.busy = 1'b0;
				end
			end else if (cmd_q.code != CODE_RESERVED) begin
				pool_d[pidx].poolRemainingEntries = pool_d[pidx].poolRemainingEntries
					+ cmd_q.lengthOrEntryCount;
				if (pool_q[pidx].poolRemainingEntries == 16'h0) begin
					pool_d[pidx].dirAddr = cmdAddr_q;
				end
				cmd_d.busy = 1'b0;
			end else begin
				cmd_d.busy = 1'b0;
			end
		end

		// Register writes land in the data phase
		if (wrPend_q) begin
			unique case (wrAddr_q)
				OFS_CMD: begin
					if (!cmd_q.busy) begin
						cmd_d.busy = 1'b1;
						cmd_d.code = hwdata[CMD_CODE_LSB +: 3];
						cmd_d.lengthOrEntryCount = hwdata[15:0];
					end
				end
				OFS_CMD_ADDR: begin
					cmdAddr_d = hwdata;
				end
				OFS_RING_START: begin
					ring_d.start = hwdata;
					ring_d.readPtr = hwdata;
					ring_d.writePtr = hwdata;
					ring_d.full = 1'b0;
				end
				OFS_RING_BOTTOM: begin
					ring_d.bottom = hwdata;
				end
				OFS_RING_READ: begin
					ring_d.readPtr = hwdata;
					ring_d.full = 1'b0;
				end
				default: begin
					// Only the threshold of a pool info word is writable
					for (int p = 0; p < 3; p++) begin
						if (wrAddr_q == OFS_POOL_BASE + 8'(p) * OFS_POOL_STRIDE) begin
							pool_d[p].poolAlertThreshold = hwdata[ALERT_LSB +: 3];
						end
					end
				end
			endcase
		end

		// Indication after the read-pointer clear so a simultaneous set wins
		if (txIndReq && !ring_q.full) begin
			ring_d.writePtr = ringNext;
			ack_d = 1'b1;
			if (ringNext == ring_d.readPtr) begin
				ring_d.full = 1'b1;
			end
		end

		for (int p = 0; p < 3; p++) begin
			low_d[p] = (pool_d[p].poolAlertThreshold != 3'h0)
				&& (pool_d[p].poolRemainingEntries
				== {11'h0, pool_d[p].poolAlertThreshold, 2'h0});
		end

		// Read data is sampled in the address phase; no read has side effects
		if (addrPhase && !hwrite) begin
			rdData_d = REG_RESET;
			unique case (haddr[7:0])
				OFS_CMD: begin
					rdData_d[CMD_BUSY_BIT] = cmd_q.busy;
					rdData_d[CMD_CODE_LSB +: 3] = cmd_q.code;
					rdData_d[15:0] = cmd_q.lengthOrEntryCount;
				end
				OFS_CMD_ADDR: rdData_d = cmdAddr_q;
				OFS_TX_QUEUE: begin
					for (int e = 0; e < 4; e++) begin
						rdData_d[e * QUEUE_FIELD_STRIDE +: 2] = depth_q[e];
					end
				end
				OFS_RING_START: rdData_d = ring_q.start;
				OFS_RING_BOTTOM: rdData_d = ring_q.bottom;
				OFS_RING_READ: rdData_d = ring_q.readPtr;
				OFS_RING_WRITE: rdData_d = ring_q.writePtr;
				default: begin
					for (int p = 0; p < 3; p++) begin
						if (haddr[7:0] == OFS_POOL_BASE + 8'(p) * OFS_POOL_STRIDE) begin
							rdData_d[ALERT_LSB +: 3] = pool_q[p].poolAlertThreshold;
							rdData_d[15:0] = pool_q[p].poolRemainingEntries;
						end
						if (haddr[7:0] == OFS_POOL_BASE + 8'(p) * OFS_POOL_STRIDE
							+ OFS_POOL_ADDR_SUB) begin
							rdData_d = pool_q[p].dirAddr;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_q <= '0;
			cmdAddr_q <= REG_RESET;
			depth_q <= '0;
			pool_q <= '0;
			low_q <= '0;
			ring_q <= '0;
			txReq_q <= '0;
			ack_q <= 1'b0;
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h0;
			rdData_q <= REG_RESET;
		end else begin
			cmd_q <= cmd_d;
			cmdAddr_q <= cmdAddr_d;
			depth_q <= depth_d;
			pool_q <= pool_d;
			low_q <= low_d;
			ring_q <= ring_d;
			txReq_q <= txReq_d;
			ack_q <= ack_d;
			wrPend_q <= wrPend_d;
			wrAddr_q <= wrAddr_d;
			rdData_q <= rdData_d;
		end
	end

	busy_write_ignored_a: assert property (@(posedge mclk) disable iff (rst)
		wrPend_q && wrAddr_q == OFS_CMD && cmd_q.busy
		|=> cmd_q.code == $past(cmd_q.code)
		&& cmd_q.lengthOrEntryCount == $past(cmd_q.lengthOrEntryCount))
		else $error("command changed while pending");

	pending_set_a: assert property (@(posedge mclk) disable iff (rst)
		wrPend_q && wrAddr_q == OFS_CMD && !cmd_q.busy |=> cmd_q.busy)
		else $error("accepted command did not set pending");

	pending_read_a: assert property (@(posedge mclk) disable iff (rst)
		hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OFS_CMD
		|=> hrdata[CMD_BUSY_BIT] == $past(cmd_q.busy))
		else $error("pending bit misreported");

	pool_add_done_a: assert property (@(posedge mclk) disable iff (rst)
		cmd_q.busy && cmd_q.code[2] |=> !cmd_q.busy)
		else $error("pool add not completed in one cycle");

	tx_issue_a: assert property (@(posedge mclk) disable iff (rst)
		txReq.valid |-> $past(cmd_q.busy) && !$past(cmd_q.code[2])
		&& txReq.slot == $past(cmd_q.code[1:0])
		&& txReq.length == $past(cmd_q.lengthOrEntryCount))
		else $error("transmit request without matching command");

	queue_limit_a: assert property (@(posedge mclk) disable iff (rst)
		depth_q[0] != 2'h3 && depth_q[1] != 2'h3 && depth_q[2] != 2'h3 && depth_q[3] != 2'h3)
		else $error("queue state out of range");

	alert_level_a: assert property (@(posedge mclk) disable iff (rst)
		poolLowFlag[0] |-> pool_q[0].poolAlertThreshold != 3'h0
		&& pool_q[0].poolRemainingEntries == {11'h0, pool_q[0].poolAlertThreshold, 2'h0})
		else $error("pool low flag without threshold match");

	ring_start_load_a: assert property (@(posedge mclk) disable iff (rst)
		wrPend_q && wrAddr_q == OFS_RING_START && !txIndReq
		|=> ring_q.readPtr == $past(hwdata) && ring_q.writePtr == $past(hwdata))
		else $error("ring start did not load pointers");

	full_blocks_a: assert property (@(posedge mclk) disable iff (rst)
		ring_q.full && txIndReq |=> !txIndAck && $stable(ring_q.writePtr))
		else $error("indication accepted while ring full");

	ring_wrap_a: assert property (@(posedge mclk) disable iff (rst)
		txIndReq && !ring_q.full && ring_q.writePtr >= ring_q.bottom
		&& !(wrPend_q && wrAddr_q == OFS_RING_START)
		|=> ring_q.writePtr == $past(ring_q.start))
		else $error("write pointer failed to wrap");

	alert_disabled_a: assert property (@(posedge mclk) disable iff (rst)
		!(poolLowFlag[0] && pool_q[0].poolAlertThreshold == 3'h0)
		&& !(poolLowFlag[1] && pool_q[1].poolAlertThreshold == 3'h0)
		&& !(poolLowFlag[2] && pool_q[2].poolAlertThreshold == 3'h0))
		else $error("pool low flag raised while disabled");

	alert_raise_a: assert property (@(posedge mclk) disable iff (rst)
		pool_q[2].poolAlertThreshold != 3'h0
		&& pool_q[2].poolRemainingEntries == {11'h0, pool_q[2].poolAlertThreshold, 2'h0}
		|-> poolLowFlag[2])
		else $error("pool low flag missing at threshold");

	// Only the engine and the consumers may move a pool's count and address, never a bus write
	count_write_ignored_a: assert property (@(posedge mclk) disable iff (rst)
		wrPend_q && wrAddr_q == OFS_POOL_BASE && !cmd_q.busy && !poolTake[0]
		|=> pool_q[0].poolRemainingEntries == $past(pool_q[0].poolRemainingEntries))
		else $error("pool count changed by a register write");

	pool_addr_ro_a: assert property (@(posedge mclk) disable iff (rst)
		wrPend_q && wrAddr_q == OFS_POOL_BASE + OFS_POOL_ADDR_SUB
		&& !cmd_q.busy && !poolTake[0]
		|=> pool_q[0].dirAddr == $past(pool_q[0].dirAddr))
		else $error("pool address changed by a register write");

	pool_add_count_a: assert property (@(posedge mclk) disable iff (rst)
		cmd_q.busy && cmd_q.code == 3'h4 && !poolTake[0]
		|=> pool_q[0].poolRemainingEntries
		== $past(pool_q[0].poolRemainingEntries) + $past(cmd_q.lengthOrEntryCount))
		else $error("pool add count not applied");

	write_ptr_ro_a: assert property (@(posedge mclk) disable iff (rst)
		wrPend_q && wrAddr_q == OFS_RING_WRITE && !txIndReq |=> $stable(ring_q.writePtr))
		else $error("write pointer changed by a register write");

	tx_addr_a: assert property (@(posedge mclk) disable iff (rst)
		txReq.valid |-> txReq.addr == $past(cmdAddr_q))
		else $error("transmit address not taken from extension register");

	tx_queue_step_a: assert property (@(posedge mclk) disable iff (rst)
		txReq.valid |-> depth_q[txReq.slot] != 2'h0)
		else $error("transmit request without a queued item");

	reserved_code_a: assert property (@(posedge mclk) disable iff (rst)
		cmd_q.busy && cmd_q.code == CODE_RESERVED && poolTake == 3'h0 && !wrPend_q
		|=> !txReq.valid && pool_q == $past(pool_q))
		else $error("reserved command changed pool or transmit state");

	full_set_a: assert property (@(posedge mclk) disable iff (rst)
		txIndReq && !ring_q.full && !wrPend_q && ringNext == ring_q.readPtr
		|=> txRingFullFlag)
		else $error("ring full flag not set");

	queue_status_a: assert property (@(posedge mclk) disable iff (rst)
		hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OFS_TX_QUEUE
		|=> hrdata[3 * QUEUE_FIELD_STRIDE +: 2] == $past(depth_q[3])
		&& hrdata[1:0] == $past(depth_q[0]))
		else $error("queue state misreported");

	cover_tx_cmd_c: cover property (@(posedge mclk) disable iff (rst)
		txReq.valid);
	cover_pool_low_c: cover property (@(posedge mclk) disable iff (rst)
		$rose(poolLowFlag[0]));
	cover_ring_full_c: cover property (@(posedge mclk) disable iff (rst)
		$rose(txRingFullFlag));
	cover_busy_hold_c: cover property (@(posedge mclk) disable iff (rst)
		cmd_q.busy [*3]);
	cover_pool_add_c: cover property (@(posedge mclk) disable iff (rst)
		cmd_q.busy && cmd_q.code[2]);
endmodule

// ---- bench/usb_command_pool_mailbox_regs_tb_top.sv ----
// Self-checking bench for the command, pool and transmit ring register set
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module usb_command_pool_mailbox_regs_tb_top import usb_cmd_pool_pkg::*;;
	logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, txIndReq = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, poolTake = 0, poolLow;
	logic [3:0] txDone = 0;
	logic [2:0][31:0] poolNextAddr = '0;
	logic hreadyout, hresp, txIndAck, ringFull;
	tx_req_t txReq, lastReq;
	int errors = 0, checks_done = 0, cyc = 0, reqCnt = 0, ackCnt = 0;

	usb_command_pool_mailbox_regs i_usb_command_pool_mailbox_regs (.mclk(mclk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .txReq(txReq), .txDone(txDone), .poolTake(poolTake),
		.poolNextAddr(poolNextAddr), .poolLowFlag(poolLow), .txIndReq(txIndReq),
		.txIndAck(txIndAck), .txRingFullFlag(ringFull));

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	// Pulses are counted 1 ns after the edge so the registered outputs have settled
	always @(posedge mclk) begin
		cyc++;
		#1;
		if (txReq.valid === 1'b1) begin
			lastReq = txReq;
			reqCnt++;
		end
		if (txIndAck === 1'b1) ackCnt++;
		if (cyc == 5000) begin
			errors++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// One AHB-Lite single transfer; read data is taken at the data-phase edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask

	task automatic poll_idle();
		do xfer(1'b0, OFS_CMD, 32'h0);
		while (rd[CMD_BUSY_BIT] !== 1'b0);
	endtask

	task automatic pulse(input logic [3:0] dn, input logic [2:0] tk, input logic ind);
		@(posedge mclk);
		txDone <= dn;
		poolTake <= tk;
		txIndReq <= ind;
		@(posedge mclk);
		txDone <= 4'h0;
		poolTake <= 3'h0;
		txIndReq <= 1'b0;
	endtask

	task automatic test_reset();
		for (int i = 0; i < 13; i++) rdc("reset value", 8'(i * 4), REG_RESET);
		wr(8'h40, 32'hffffffff);
		rdc("unmapped", 8'h40, 32'h0);
		`CHK("hresp", 1'b0, hresp)
		`CHK("hreadyout", 1'b1, hreadyout)
	endtask

	task automatic test_tx();
		int n;
		for (int c = 0; c < 4; c++) begin
			n = reqCnt;
			wr(OFS_CMD_ADDR, 32'h1000 + 32'(c * 16));
			wr(OFS_CMD, {5'h0, 3'(c), 8'h0, 16'h40 + 16'(c)});
			rdc("cmd done", OFS_CMD, {5'h0, 3'(c), 8'h0, 16'h40 + 16'(c)});
			`CHK("req count", n + 1, reqCnt)
			`CHK("req slot", 2'(c), lastReq.slot)
			`CHK("req length", 16'h40 + 16'(c), lastReq.length)
			`CHK("req addr", 32'h1000 + 32'(c * 16), lastReq.addr)
		end
		rdc("queue", OFS_TX_QUEUE, 32'h01010101);
		rdc("queue reread", OFS_TX_QUEUE, 32'h01010101);
		wr(OFS_CMD, 32'h00000011);
		poll_idle();
		// Third queued item on endpoint 0 has no slot and must stay pending
		wr(OFS_CMD, 32'h00000077);
		rdc("cmd pending", OFS_CMD, 32'h80000077);
		wr(OFS_CMD, 32'h03000005);
		rdc("cmd locked", OFS_CMD, 32'h80000077);
		rdc("queue full", OFS_TX_QUEUE, 32'h01010102);
		n = reqCnt;
		pulse(4'h1, 3'h0, 1'b0);
		rdc("cmd released", OFS_CMD, 32'h00000077);
		`CHK("late req", n + 1, reqCnt)
		pulse(4'hf, 3'h0, 1'b0);
		pulse(4'hf, 3'h0, 1'b0);
		rdc("queue drained", OFS_TX_QUEUE, 32'h0);
	endtask

	task automatic test_pool();
		logic [7:0] inf;
		for (int p = 0; p < 3; p++) begin
			inf = OFS_POOL_BASE + 8'(p * 8);
			wr(inf, 32'h1000ffff);
			wr(inf + OFS_POOL_ADDR_SUB, 32'hdeadbeef);
			wr(OFS_CMD_ADDR, 32'h2000 + 32'(p * 256));
			wr(OFS_CMD, {5'h0, 3'(4 + p), 8'h0, 16'h5});
			rdc("pool info", inf, 32'h10000005);
			rdc("pool addr", inf + OFS_POOL_ADDR_SUB, 32'h2000 + 32'(p * 256));
			`CHK("low flag idle", 3'h0, poolLow)
			poolNextAddr[p] <= 32'h3000 + 32'(p);
			pulse(4'h0, 3'(1 << p), 1'b0);
			rdc("pool take", inf, 32'h10000004);
			`CHK("low flag", 3'(1 << p), poolLow)
			rdc("pool next", inf + OFS_POOL_ADDR_SUB, 32'h3000 + 32'(p));
			wr(inf, 32'h0);
			rdc("pool off", inf, 32'h00000004);
			`CHK("low flag off", 3'h0, poolLow)
		end
		wr(OFS_CMD, 32'h07000000);
		rdc("reserved code", OFS_CMD, 32'h07000000);
	endtask

	task automatic test_ring();
		int n;
		wr(OFS_RING_START, 32'h100);
		wr(OFS_RING_BOTTOM, 32'h108);
		rdc("read ptr", OFS_RING_READ, 32'h100);
		rdc("write ptr", OFS_RING_WRITE, 32'h100);
		n = ackCnt;
		for (int i = 0; i < 3; i++) begin
			pulse(4'h0, 3'h0, 1'b1);
			rdc("ring step", OFS_RING_WRITE, (i < 2) ? 32'h104 + 32'(i * 4) : 32'h100);
		end
		`CHK("acks", n + 3, ackCnt)
		`CHK("full", 1'b1, ringFull)
		pulse(4'h0, 3'h0, 1'b1);
		rdc("held ptr", OFS_RING_WRITE, 32'h100);
		`CHK("held acks", n + 3, ackCnt)
		wr(OFS_RING_READ, 32'h104);
		rdc("read ptr moved", OFS_RING_READ, 32'h104);
		`CHK("full cleared", 1'b0, ringFull)
		pulse(4'h0, 3'h0, 1'b1);
		wr(OFS_RING_WRITE, 32'h0);
		rdc("write ptr ro", OFS_RING_WRITE, 32'h104);
		`CHK("full again", 1'b1, ringFull)
		`CHK("acks again", n + 4, ackCnt)
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		test_reset();
		test_tx();
		test_pool();
		test_ring();
		end_sim();
	end
endmodule
